// *** core/flash_status_pkg.sv ***
package flash_status_pkg;

	// ------------------------------------------------------------
	// Instruction codes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_READ_SR_LOW = 8'h05;
	localparam logic [7:0] OP_READ_SR_MID = 8'h35;
	localparam logic [7:0] OP_READ_SR_HIGH = 8'h15;
	localparam logic [7:0] OP_WRITE_SR_LOW = 8'h01;
	localparam logic [7:0] OP_WRITE_SR_MID = 8'h31;
	localparam logic [7:0] OP_WRITE_SR_HIGH = 8'h11;
	localparam logic [7:0] OP_ENTER_WIDE = 8'hb7;
	localparam logic [7:0] OP_EXIT_WIDE = 8'he9;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7a;
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;

	// ------------------------------------------------------------
	// Field positions inside the three status bytes
	// ------------------------------------------------------------
	localparam int LOW_LOCK_POS = 7;
	localparam int LOW_PROTECT_MSB = 6;
	localparam int LOW_PROTECT_LSB = 2;
	localparam int MID_COMPLEMENT_POS = 6;
	localparam int MID_AREA_LOCK_MSB = 5;
	localparam int MID_AREA_LOCK_LSB = 3;
	localparam int MID_QUAD_POS = 1;
	localparam int MID_LOCK_POS = 0;
	localparam int HIGH_PIN_FUNC_POS = 7;
	localparam int HIGH_DRIVE_MSB = 6;
	localparam int HIGH_DRIVE_LSB = 5;
	localparam int HIGH_SCHEME_POS = 2;
	localparam int HIGH_POWERUP_POS = 1;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [4:0] PROTECT_RESET = 5'h00;
	localparam logic [2:0] AREA_LOCK_RESET = 3'h0;
	localparam logic [1:0] DRIVE_RESET = 2'h0;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// ------------------------------------------------------------
	// Link framing and pin synchroniser layout
	// ------------------------------------------------------------
	localparam logic [4:0] BITS_OPCODE_LAST = 5'h07;
	localparam logic [4:0] BITS_DATA_LAST = 5'h0f;
	localparam logic [4:0] BITS_FULL = 5'h10;
	localparam int PIN_CS = 0;
	localparam int PIN_WP = 1;
	localparam int PIN_HOLD = 2;
	localparam int PIN_TOGGLE = 3;
	localparam logic [3:0] PIN_SYNC_RESET = 4'h7;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int SYS_PERIOD_NS = 10;
	localparam int STATUS_WRITE_NS = 5000;
	localparam logic [9:0] STATUS_WRITE_CYC =
		10'((STATUS_WRITE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);

	typedef enum logic [1:0] {
		KIND_PROGRAM,
		KIND_SECTOR_ERASE,
		KIND_BLOCK_ERASE,
		KIND_CHIP_ERASE
	} op_kind_t;

	typedef enum logic [1:0] {
		ENG_IDLE,
		ENG_STATUS_WRITE,
		ENG_ARRAY,
		ENG_SUSPENDED
	} engine_state_t;

endpackage

// *** core/flash_status_control.sv ***
`timescale 1ns/1ps
module flash_status_control (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic link_clk,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	input wire logic wp_n,
	input wire logic hold_rst_n,
	input wire logic array_region_protected,
	input wire logic sector_guard_hit,
	input wire logic op_done,
	output logic op_start,
	output flash_status_pkg::op_kind_t op_kind,
	output logic [4:0] protect_level_field,
	output logic complement_bit,
	output logic quad_io_enable,
	output logic hold_active,
	output logic pin_reset_request,
	output logic [1:0] output_drive_strength,
	output logic current_width_flag,
	output logic protection_scheme_select,
	output logic [2:0] security_area_lock_bits
);
	import flash_status_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic frame_clear;
	logic [4:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] shift_next;
	logic [7:0] out_shift;
	logic [7:0] read_byte;
	logic read_hit;
	logic rd_active;
	logic [7:0] opcode;
	logic [7:0] data;
	logic data_got;
	logic op_toggle;
	logic [3:0] pin_raw;
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic [3:0] pin_s3;
	logic [3:0] pin_filt;
	logic cs_seen;
	logic op_seen;
	logic cs_rise;
	logic exec;
	engine_state_t state;
	logic [9:0] wcnt;
	logic write_busy_flag;
	logic write_latch_flag;
	logic status_lock_low;
	logic status_lock_high;
	logic erase_paused_flag;
	logic program_paused_flag;
	logic powerup_width_bit;
	logic hold_rst_sel;
	logic running_erase;
	logic init_pending;
	logic [7:0] status_byte_low;
	logic [7:0] status_byte_mid;
	logic [7:0] status_byte_high;
	logic [7:0] snap_low;
	logic [7:0] snap_mid;
	logic [7:0] snap_high;
	logic is_sr_write;
	logic is_array;
	logic wp_high;
	logic lock_ok;
	logic chip_ok;
	logic region_ok;
	logic do_sr_write;
	logic do_array;
	logic sw_done;
	op_kind_t next_kind;

	// ------------------------------------------------------------
	// Link side, clocked by the host's serial clock
	// ------------------------------------------------------------
	// The frame's own select line clears the bit counter, so nothing
	// relies on clock edges outside a frame.
	assign frame_clear = cs_n | reset;
	assign shift_next = {shift[6:0], si};

	always_comb begin
		read_hit = 1'b1;
		read_byte = snap_low;
		case (shift_next)
			OP_READ_SR_LOW: read_byte = snap_low;
			OP_READ_SR_MID: read_byte = snap_mid;
			OP_READ_SR_HIGH: read_byte = snap_high;
			default: read_hit = 1'b0;
		endcase
	end

	always_ff @(posedge link_clk or posedge frame_clear) begin
		if (frame_clear) begin
			bit_cnt <= 5'h00;
			shift <= BYTE_RESET;
			out_shift <= BYTE_RESET;
			rd_active <= 1'b0;
		end else begin
			shift <= shift_next;
			if (bit_cnt != BITS_FULL) begin
				bit_cnt <= bit_cnt + 5'h01;
			end
			if (bit_cnt == BITS_OPCODE_LAST) begin
				rd_active <= read_hit;
				out_shift <= read_byte;
			end else begin
				out_shift <= {out_shift[6:0], out_shift[7]};
			end
		end
	end

	// Opcode and data stay put after the frame; the system side takes
	// them once the opcode toggle and the select rise are synchronised.
	always_ff @(posedge link_clk or posedge reset) begin
		if (reset) begin
			opcode <= BYTE_RESET;
			data <= BYTE_RESET;
			data_got <= 1'b0;
			op_toggle <= 1'b0;
		end else if (bit_cnt == BITS_OPCODE_LAST) begin
			opcode <= shift_next;
			data_got <= 1'b0;
			op_toggle <= ~op_toggle;
		end else if (bit_cnt == BITS_DATA_LAST) begin
			data <= shift_next;
			data_got <= 1'b1;
		end
	end

	always_ff @(negedge link_clk or posedge frame_clear) begin
		if (frame_clear) begin
			so <= 1'b0;
			so_oe <= 1'b0;
		end else begin
			so <= out_shift[7];
			so_oe <= rd_active;
		end
	end

	// ------------------------------------------------------------
	// Pin and toggle synchronisers
	// ------------------------------------------------------------
	assign pin_raw = {op_toggle, hold_rst_n, wp_n, cs_n};

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pin_s1 <= PIN_SYNC_RESET;
			pin_s2 <= PIN_SYNC_RESET;
			pin_s3 <= PIN_SYNC_RESET;
			pin_filt <= PIN_SYNC_RESET;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_filt <= (pin_filt & ~(pin_s2 ^ pin_s3)) | (pin_s3 & ~(pin_s2 ^ pin_s3));
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cs_seen <= 1'b1;
			op_seen <= 1'b0;
		end else begin
			cs_seen <= pin_filt[PIN_CS];
			if (cs_rise) begin
				op_seen <= pin_filt[PIN_TOGGLE];
			end
		end
	end

	assign cs_rise = pin_filt[PIN_CS] & ~cs_seen;
	assign exec = cs_rise & (pin_filt[PIN_TOGGLE] != op_seen);

	// ------------------------------------------------------------
	// Instruction checks
	// ------------------------------------------------------------
	assign is_sr_write = (opcode == OP_WRITE_SR_LOW) |
		(opcode == OP_WRITE_SR_MID) | (opcode == OP_WRITE_SR_HIGH);
	assign is_array = (opcode == OP_PAGE_PROGRAM) |
		(opcode == OP_SECTOR_ERASE) | (opcode == OP_BLOCK_ERASE) |
		(opcode == OP_CHIP_ERASE);
	// With quad on, the protect pin is a data line and cannot lock.
	assign wp_high = quad_io_enable | pin_filt[PIN_WP];
	assign lock_ok = ({status_lock_high, status_lock_low} == 2'b00) |
		(({status_lock_high, status_lock_low} == 2'b01) & wp_high);
	assign do_sr_write = exec & is_sr_write & write_latch_flag &
		(state == ENG_IDLE) & lock_ok & data_got;
	assign chip_ok = protection_scheme_select |
		((protect_level_field[2:0] == 3'h0) & ~complement_bit) |
		((protect_level_field[2:0] == 3'h7) & complement_bit);
	assign region_ok = protection_scheme_select ? ~sector_guard_hit :
		~array_region_protected;
	assign do_array = exec & is_array & write_latch_flag &
		(state == ENG_IDLE) &
		((opcode == OP_CHIP_ERASE) ? chip_ok : region_ok);
	assign sw_done = (state == ENG_STATUS_WRITE) & (wcnt == 10'h001);

	always_comb begin
		next_kind = KIND_PROGRAM;
		case (opcode)
			OP_SECTOR_ERASE: next_kind = KIND_SECTOR_ERASE;
			OP_BLOCK_ERASE: next_kind = KIND_BLOCK_ERASE;
			OP_CHIP_ERASE: next_kind = KIND_CHIP_ERASE;
			default: next_kind = KIND_PROGRAM;
		endcase
	end

	// ------------------------------------------------------------
	// Engine state and busy flag
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= ENG_IDLE;
			wcnt <= 10'h000;
			running_erase <= 1'b0;
		end else begin
			unique case (state)
				ENG_IDLE: begin
					if (do_sr_write) begin
						state <= ENG_STATUS_WRITE;
						wcnt <= STATUS_WRITE_CYC;
					end else if (do_array) begin
						state <= ENG_ARRAY;
						running_erase <= (opcode != OP_PAGE_PROGRAM);
					end
				end
				ENG_STATUS_WRITE: begin
					wcnt <= wcnt - 10'h001;
					if (sw_done) begin
						state <= ENG_IDLE;
					end
				end
				ENG_ARRAY: begin
					if (op_done) begin
						state <= ENG_IDLE;
					end else if (exec & (opcode == OP_SUSPEND)) begin
						state <= ENG_SUSPENDED;
					end
				end
				ENG_SUSPENDED: begin
					if (exec & (opcode == OP_RESUME)) begin
						state <= ENG_ARRAY;
					end
				end
			endcase
		end
	end

	assign write_busy_flag = (state == ENG_STATUS_WRITE) |
		(state == ENG_ARRAY);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			op_start <= 1'b0;
			op_kind <= KIND_PROGRAM;
		end else begin
			op_start <= do_array;
			if (do_array) begin
				op_kind <= next_kind;
			end
		end
	end

	// ------------------------------------------------------------
	// Write enable latch
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			write_latch_flag <= 1'b0;
		end else if (exec & (opcode == OP_WRITE_ENABLE) & ~write_busy_flag) begin
			write_latch_flag <= 1'b1;
		end else if ((exec & (opcode == OP_WRITE_DISABLE)) | sw_done |
			((state == ENG_ARRAY) & op_done)) begin
			write_latch_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Suspend flags
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			erase_paused_flag <= 1'b0;
			program_paused_flag <= 1'b0;
		end else if ((state == ENG_ARRAY) & ~op_done & exec &
			(opcode == OP_SUSPEND)) begin
			erase_paused_flag <= running_erase;
			program_paused_flag <= ~running_erase;
		end else if ((state == ENG_SUSPENDED) & exec & (opcode == OP_RESUME)) begin
			erase_paused_flag <= 1'b0;
			program_paused_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Writable status fields
	// ------------------------------------------------------------
	// Reset stands for a power cycle: lock bits return to 00.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			status_lock_low <= 1'b0;
			status_lock_high <= 1'b0;
			protect_level_field <= PROTECT_RESET;
			complement_bit <= 1'b0;
			security_area_lock_bits <= AREA_LOCK_RESET;
			quad_io_enable <= 1'b0;
			hold_rst_sel <= 1'b0;
			output_drive_strength <= DRIVE_RESET;
			protection_scheme_select <= 1'b0;
			powerup_width_bit <= 1'b0;
		end else if (do_sr_write) begin
			// Busy, latch, paused and current width bits are never taken from data.
			unique case (opcode)
				OP_WRITE_SR_LOW: begin
					status_lock_low <= data[LOW_LOCK_POS];
					protect_level_field <=
						data[LOW_PROTECT_MSB:LOW_PROTECT_LSB];
				end
				OP_WRITE_SR_MID: begin
					complement_bit <= data[MID_COMPLEMENT_POS];
					security_area_lock_bits <= security_area_lock_bits |
						data[MID_AREA_LOCK_MSB:MID_AREA_LOCK_LSB];
					quad_io_enable <= data[MID_QUAD_POS];
					status_lock_high <= data[MID_LOCK_POS];
				end
				OP_WRITE_SR_HIGH: begin
					hold_rst_sel <= data[HIGH_PIN_FUNC_POS];
					output_drive_strength <=
						data[HIGH_DRIVE_MSB:HIGH_DRIVE_LSB];
					protection_scheme_select <= protection_scheme_select |
						data[HIGH_SCHEME_POS];
					powerup_width_bit <= data[HIGH_POWERUP_POS];
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Address width
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			init_pending <= 1'b1;
			current_width_flag <= 1'b0;
		end else begin
			init_pending <= 1'b0;
			if (init_pending) begin
				current_width_flag <= powerup_width_bit;
			end else if (exec & ~write_busy_flag & (opcode == OP_ENTER_WIDE)) begin
				current_width_flag <= 1'b1;
			end else if (exec & ~write_busy_flag & (opcode == OP_EXIT_WIDE)) begin
				current_width_flag <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Shared pin functions
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			hold_active <= 1'b0;
			pin_reset_request <= 1'b0;
		end else begin
			hold_active <= ~quad_io_enable & ~hold_rst_sel &
				~pin_filt[PIN_HOLD];
			pin_reset_request <= ~quad_io_enable & hold_rst_sel &
				~pin_filt[PIN_HOLD];
		end
	end

	// ------------------------------------------------------------
	// Status bytes and read snapshot
	// ------------------------------------------------------------
	assign status_byte_low = {status_lock_low, protect_level_field,
		write_latch_flag, write_busy_flag};
	assign status_byte_mid = {erase_paused_flag, complement_bit,
		security_area_lock_bits, program_paused_flag, quad_io_enable,
		status_lock_high};
	assign status_byte_high = {hold_rst_sel, output_drive_strength, 2'b00,
		protection_scheme_select, powerup_width_bit, current_width_flag};

	// The snapshot only moves between frames, so the link side reads a
	// stable byte during a frame.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			snap_low <= BYTE_RESET;
			snap_mid <= BYTE_RESET;
			snap_high <= BYTE_RESET;
		end else if (pin_filt[PIN_CS]) begin
			snap_low <= status_byte_low;
			snap_mid <= status_byte_mid;
			snap_high <= status_byte_high;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_suspend;
		exec && opcode == OP_SUSPEND && state == ENG_ARRAY && !op_done;
	endsequence
	sequence s_resume;
		exec && opcode == OP_RESUME && state == ENG_SUSPENDED;
	endsequence

	a_busy_status_write: assert property (
		do_sr_write |=> write_busy_flag [*8])
		else $error("busy flag dropped during status write");
	a_latch_gates_write: assert property (
		exec && (is_sr_write || is_array) && !write_latch_flag &&
		state == ENG_IDLE |=> state == ENG_IDLE && !op_start)
		else $error("write accepted with latch clear");
	a_region_refused: assert property (
		exec && is_array && opcode != OP_CHIP_ERASE &&
		!protection_scheme_select && array_region_protected |=> !op_start)
		else $error("protected region operation started");
	a_chip_erase_gate: assert property (
		op_start && op_kind == KIND_CHIP_ERASE && !protection_scheme_select
		|-> $past((protect_level_field[2:0] == 3'h0 && !complement_bit) ||
		(protect_level_field[2:0] == 3'h7 && complement_bit)))
		else $error("chip erase started with wrong protect pattern");
	a_pin_lock_holds: assert property (
		exec && is_sr_write && !status_lock_high && status_lock_low &&
		!quad_io_enable && !pin_filt[PIN_WP] |=>
		$stable(protect_level_field) && $stable(status_lock_low))
		else $error("status written while pin locked");
	a_lockdown_holds: assert property (
		exec && is_sr_write && status_lock_high && !write_busy_flag |=>
		$stable(status_lock_high) && $stable(quad_io_enable) &&
		!write_busy_flag)
		else $error("status written while locked down");
	a_scheme_sticky: assert property (
		protection_scheme_select |=> protection_scheme_select)
		else $error("scheme select returned to zero");
	a_area_lock_sticky: assert property (
		(security_area_lock_bits & $past(security_area_lock_bits)) ==
		$past(security_area_lock_bits))
		else $error("security area lock bit cleared");
	a_suspend_flags: assert property (
		s_suspend |=> state == ENG_SUSPENDED &&
		(erase_paused_flag != program_paused_flag))
		else $error("suspend did not set one paused flag");
	a_resume_clears: assert property (
		s_suspend ##[1:200] s_resume |=>
		!erase_paused_flag && !program_paused_flag)
		else $error("resume left a paused flag set");
	a_width_enter: assert property (
		exec && opcode == OP_ENTER_WIDE && !write_busy_flag && !init_pending
		|=> current_width_flag)
		else $error("width flag did not follow enter");
	a_read_only_bits: assert property (
		do_sr_write && opcode == OP_WRITE_SR_MID |=>
		$stable(erase_paused_flag) && $stable(program_paused_flag))
		else $error("status write changed a paused flag");

endmodule

// *** tb/spi_host.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Host side of the serial link
// ----------------------------------------
module spi_host (
	output logic link_clk,
	output logic cs_n,
	output logic si,
	input wire logic so,
	input wire logic so_oe
);
	initial begin
		link_clk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// The clock stands low between frames; si flips once released.
	task automatic frame(input logic [15:0] bits, input int n,
		output logic [7:0] rd);
		rd = 8'h00;
		cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			si = bits[15 - i];
			#24;
			link_clk = 1'b1;
			if (i >= 8 && so_oe === 1'b1) rd = {rd[6:0], so};
			#24;
			link_clk = 1'b0;
		end
		#24;
		cs_n = 1'b1;
		si = ~si;
		#100;
	endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Status and control bench
// ----------------------------------------
module tb;
	import flash_status_pkg::*;
	typedef struct {
		logic [7:0] w, d, r, e;
	} row_t;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic wp_n = 1'b1;
	logic hold_rst_n = 1'b1;
	logic region = 1'b0;
	logic guard = 1'b0;
	logic op_done = 1'b0;
	logic link_clk, cs_n, si, so, so_oe, op_start, cmp, quad, hold, prst;
	logic wide, scheme;
	op_kind_t op_kind;
	logic [4:0] prot;
	logic [1:0] drv;
	logic [2:0] area;
	logic [7:0] v;
	int mismatches = 0;
	int n_checks = 0;
	int starts = 0;
	int s0;
	logic [7:0] rdop[3] = '{OP_READ_SR_LOW, OP_READ_SR_MID, OP_READ_SR_HIGH};
	logic [7:0] opc[3] = '{OP_PAGE_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK_ERASE};
	logic [7:0] susp[3] = '{8'h04, 8'h80, 8'h80};
	row_t rows[8] = '{
		'{OP_WRITE_SR_LOW, 8'h7f, OP_READ_SR_LOW, 8'h7c},
		'{OP_WRITE_SR_MID, 8'hc6, OP_READ_SR_MID, 8'h42},
		'{OP_WRITE_SR_MID, 8'h00, OP_READ_SR_MID, 8'h00},
		'{OP_WRITE_SR_HIGH, 8'he3, OP_READ_SR_HIGH, 8'he2},
		'{OP_WRITE_SR_HIGH, 8'h40, OP_READ_SR_HIGH, 8'h40},
		'{OP_WRITE_SR_HIGH, 8'h20, OP_READ_SR_HIGH, 8'h20},
		'{OP_WRITE_SR_HIGH, 8'h00, OP_READ_SR_HIGH, 8'h00},
		'{OP_WRITE_SR_LOW, 8'h00, OP_READ_SR_LOW, 8'h00}};
	flash_status_control i_dut (.clk_sys(clk_sys), .reset(reset),
		.link_clk(link_clk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
		.wp_n(wp_n), .hold_rst_n(hold_rst_n),
		.array_region_protected(region), .sector_guard_hit(guard),
		.op_done(op_done), .op_start(op_start), .op_kind(op_kind),
		.protect_level_field(prot), .complement_bit(cmp),
		.quad_io_enable(quad), .hold_active(hold),
		.pin_reset_request(prst), .output_drive_strength(drv),
		.current_width_flag(wide), .protection_scheme_select(scheme),
		.security_area_lock_bits(area));
	spi_host i_host (.link_clk(link_clk), .cs_n(cs_n), .si(si), .so(so),
		.so_oe(so_oe));
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (op_start === 1'b1) starts++;
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task power;
		cyc(1);
		reset = 1'b1;
		cyc(4);
		reset = 1'b0;
		cyc(3);
	endtask
	task pulse;
		cyc(1);
		op_done = 1'b1;
		cyc(1);
		op_done = 1'b0;
	endtask
	task cmd(input logic [7:0] c);
		i_host.frame({c, 8'h00}, 8, v);
	endtask
	task rd(input logic [7:0] c);
		i_host.frame({c, 8'h00}, 16, v);
	endtask
	task idle;
		for (int k = 0; k < 20; k++) begin
			rd(OP_READ_SR_LOW);
			if (v[0] === 1'b0) return;
		end
		mismatches++;
		give_verdict();
	endtask
	task wr(input logic [7:0] c, d);
		cmd(OP_WRITE_ENABLE);
		i_host.frame({c, d}, 16, v);
		idle();
	endtask
	initial begin
		#800000;
		mismatches++;
		give_verdict();
	end
	initial begin
		power();
		foreach (rdop[i]) begin
			rd(rdop[i]);
			chk("reset value", v, 8'h00);
		end
		i_host.frame({OP_WRITE_SR_MID, 8'h02}, 16, v);
		rd(OP_READ_SR_MID);
		chk("no latch", v, 8'h00);
		cmd(OP_WRITE_ENABLE);
		i_host.frame({OP_WRITE_SR_LOW, 8'h00}, 16, v);
		rd(OP_READ_SR_LOW);
		chk("busy", v, 8'h03);
		idle();
		chk("latch clear", v, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i].w, rows[i].d);
			rd(rows[i].r);
			chk("row", v, rows[i].e);
		end
		cmd(OP_ENTER_WIDE);
		chk("wide", 8'(wide), 8'h01);
		rd(OP_READ_SR_HIGH);
		chk("wide byte", v, 8'h01);
		cmd(OP_EXIT_WIDE);
		chk("narrow", 8'(wide), 8'h00);
		cyc(1);
		hold_rst_n = 1'b0;
		cyc(8);
		chk("hold", 8'({hold, prst}), 8'h02);
		wr(OP_WRITE_SR_HIGH, 8'h80);
		chk("pin reset", 8'({hold, prst}), 8'h01);
		wr(OP_WRITE_SR_MID, 8'h02);
		chk("quad pins", 8'({hold, prst, quad}), 8'h01);
		wr(OP_WRITE_SR_MID, 8'h00);
		wr(OP_WRITE_SR_HIGH, 8'h00);
		cyc(1);
		hold_rst_n = 1'b1;
		foreach (opc[i]) begin
			s0 = starts;
			cmd(OP_WRITE_ENABLE);
			cmd(opc[i]);
			chk("start", 8'(starts - s0), 8'h01);
			chk("kind", 8'(op_kind), 8'(i));
			rd(OP_READ_SR_LOW);
			chk("op busy", v, 8'h03);
			cmd(OP_SUSPEND);
			rd(OP_READ_SR_MID);
			chk("paused", v, susp[i]);
			cmd(OP_RESUME);
			rd(OP_READ_SR_MID);
			chk("resumed", v, 8'h00);
			pulse();
			idle();
		end
		s0 = starts;
		cyc(1);
		region = 1'b1;
		cmd(OP_WRITE_ENABLE);
		cmd(OP_SECTOR_ERASE);
		cyc(1);
		region = 1'b0;
		wr(OP_WRITE_SR_LOW, 8'h04);
		cmd(OP_WRITE_ENABLE);
		cmd(OP_CHIP_ERASE);
		chk("refused", 8'(starts - s0), 8'h00);
		wr(OP_WRITE_SR_LOW, 8'h00);
		cmd(OP_WRITE_ENABLE);
		cmd(OP_CHIP_ERASE);
		chk("chip erase", 8'(starts - s0), 8'h01);
		chk("chip kind", 8'(op_kind), 8'h03);
		pulse();
		idle();
		wr(OP_WRITE_SR_LOW, 8'h80);
		cyc(1);
		wp_n = 1'b0;
		wr(OP_WRITE_SR_LOW, 8'h84);
		rd(OP_READ_SR_LOW);
		chk("wp low", v & 8'hfc, 8'h80);
		cyc(1);
		wp_n = 1'b1;
		wr(OP_WRITE_SR_LOW, 8'h84);
		chk("wp high", 8'(prot), 8'h01);
		wr(OP_WRITE_SR_LOW, 8'h00);
		wr(OP_WRITE_SR_MID, 8'h01);
		wr(OP_WRITE_SR_LOW, 8'h04);
		chk("lock down", 8'(prot), 8'h00);
		power();
		rd(OP_READ_SR_MID);
		chk("lock cleared", v, 8'h00);
		wr(OP_WRITE_SR_MID, 8'h48);
		chk("complement", 8'(cmp), 8'h01);
		wr(OP_WRITE_SR_MID, 8'h00);
		chk("area lock", 8'(area), 8'h01);
		wr(OP_WRITE_SR_HIGH, 8'h64);
		chk("drive", 8'(drv), 8'h03);
		wr(OP_WRITE_SR_HIGH, 8'h00);
		chk("scheme", 8'(scheme), 8'h01);
		s0 = starts;
		cyc(1);
		guard = 1'b1;
		region = 1'b1;
		cmd(OP_WRITE_ENABLE);
		cmd(OP_BLOCK_ERASE);
		chk("guarded", 8'(starts - s0), 8'h00);
		cyc(1);
		guard = 1'b0;
		cmd(OP_BLOCK_ERASE);
		chk("guard off", 8'(starts - s0), 8'h01);
		pulse();
		idle();
		cyc(1);
		region = 1'b0;
		wr(OP_WRITE_SR_LOW, 8'h80);
		wr(OP_WRITE_SR_MID, 8'h01);
		wr(OP_WRITE_SR_LOW, 8'h04);
		rd(OP_READ_SR_LOW);
		chk("otp lock", v & 8'hfc, 8'h80);
		give_verdict();
	end
endmodule
